/* rtl/abl_pkg.sv */
// Package with constants and enumerations for the data arithmetic register file.
package abl_pkg;
  localparam int WORD_W = 24;
  localparam int PAIR_W = 48;
  localparam int ACC_W = 56;
  localparam int EXT_W = 8;
  localparam int HALF_W = 16;
  localparam int PAD_W = 8;
  localparam int SR_W = 24;
  localparam int SR_GROWTH_BIT = 7;
  localparam int SR_SIXTEEN_BIT = 17;
  localparam logic [SR_W-1:0] SR_RST = 24'h000000;
  localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
  localparam logic [EXT_W-1:0] EXT_RST = 8'h00;

  // Destination of a load from the buses.
  typedef enum logic [3:0] {
    ABL_DST_NONE = 4'h0,
    ABL_DST_X_LOW = 4'h1,
    ABL_DST_X_HIGH = 4'h2,
    ABL_DST_Y_LOW = 4'h3,
    ABL_DST_Y_HIGH = 4'h4,
    ABL_DST_X_PAIR = 4'h5,
    ABL_DST_Y_PAIR = 4'h6,
    ABL_DST_ACC_LOWER = 4'h7,
    ABL_DST_ACC_UPPER = 4'h8,
    ABL_DST_ACC_EXT = 4'h9,
    ABL_DST_ACC_COMBINED = 4'ha,
    ABL_DST_ACC_FULL = 4'hb
  } abl_dst_t;

  // Source of a store onto the buses.
  typedef enum logic [2:0] {
    ABL_SRC_NONE = 3'h0,
    ABL_SRC_ACC_FULL = 3'h1,
    ABL_SRC_ACC_PART = 3'h2,
    ABL_SRC_REG = 3'h3
  } abl_src_t;
endpackage : abl_pkg

/* rtl/abl_alu_regs.sv */
// Data arithmetic register file with sixteen-bit load mapping and growth flag.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Accumulator-to-bus move sets sticky growth flag bit 7.
// - 24-bit inputs pair to 48; two 56-bit accumulators.
// - Sixteen-bit mode bit enables sixteen-bit arithmetic.
// - Sixteen-bit operands 16/32/40; results 40-bit.
// - Transfers stay 24 or 48 bits wide.
// - Single-bus full accumulator load: high, clear, extend.
// - Two-bus full accumulator load (sixteen-bit mode with Y select only): X high, Y low.
// - Single-bus section load fills top 16 bits.
// - Extension load takes low 8 bus bits.
// - Two-bus pair load: X upper, Y lower, extension kept.
// - Operand low bytes read as zero; results forced zero.
module abl_alu_regs
  import abl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_valid_i,
  input wire abl_dst_t load_dst_i,
  input wire logic load_use_y_i,
  input wire logic load_acc_sel_i,
  input wire logic [WORD_W-1:0] x_data_bus_i,
  input wire logic [WORD_W-1:0] y_data_bus_i,
  input wire logic store_valid_i,
  input wire abl_src_t store_src_i,
  input wire logic status_wr_i,
  input wire logic [SR_W-1:0] status_wdata_i,
  input wire logic result_valid_i,
  input wire logic result_acc_sel_i,
  input wire logic [ACC_W-1:0] result_i,
  output logic [SR_W-1:0] status_register_o,
  output logic sixteen_bit_mode_o,
  output logic block_growth_flag_o,
  output logic [WORD_W-1:0] input_x_low_o,
  output logic [WORD_W-1:0] input_x_high_o,
  output logic [WORD_W-1:0] input_y_low_o,
  output logic [WORD_W-1:0] input_y_high_o,
  output logic [ACC_W-1:0] acc_first_o,
  output logic [ACC_W-1:0] acc_second_o,
  output logic [PAIR_W-1:0] operand_x_o,
  output logic [PAIR_W-1:0] operand_y_o,
  output logic [ACC_W-1:0] operand_acc_first_o,
  output logic [ACC_W-1:0] operand_acc_second_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SR_W-1:0] status;
    logic [WORD_W-1:0] x_low;
    logic [WORD_W-1:0] x_high;
    logic [WORD_W-1:0] y_low;
    logic [WORD_W-1:0] y_high;
    logic [EXT_W-1:0] ext_first;
    logic [WORD_W-1:0] upper_first;
    logic [WORD_W-1:0] lower_first;
    logic [EXT_W-1:0] ext_second;
    logic [WORD_W-1:0] upper_second;
    logic [WORD_W-1:0] lower_second;
  } abl_state_t;

  abl_state_t state_r;
  abl_state_t state_nxt;

  logic sixteen;
  logic [WORD_W-1:0] one_bus;
  logic [WORD_W-1:0] hi_x;
  logic [WORD_W-1:0] hi_y;
  logic [WORD_W-1:0] hi_one;
  logic [EXT_W-1:0] sign_x;
  logic [EXT_W-1:0] sign_one;
  logic [WORD_W-1:0] res_lower;
  logic [WORD_W-1:0] res_upper;

  assign sixteen = state_r.status[SR_SIXTEEN_BIT];
  assign one_bus = load_use_y_i ? y_data_bus_i : x_data_bus_i;

  // In sixteen-bit mode the bus's low 16 bits go to the top of a word.
  assign hi_x = sixteen ? {x_data_bus_i[HALF_W-1:0], {PAD_W{1'b0}}} : x_data_bus_i;
  assign hi_y = sixteen ? {y_data_bus_i[HALF_W-1:0], {PAD_W{1'b0}}} : y_data_bus_i;
  assign hi_one = sixteen ? {one_bus[HALF_W-1:0], {PAD_W{1'b0}}} : one_bus;
  assign sign_x = {EXT_W{hi_x[WORD_W-1]}};
  assign sign_one = {EXT_W{hi_one[WORD_W-1]}};

  // Results lose their low byte per word in sixteen-bit mode.
  assign res_lower = sixteen ? {result_i[WORD_W-1:PAD_W], {PAD_W{1'b0}}} : result_i[WORD_W-1:0];
  assign res_upper = sixteen ? {result_i[PAIR_W-1:WORD_W+PAD_W], {PAD_W{1'b0}}} :
                               result_i[PAIR_W-1:WORD_W];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [EXT_W-1:0] e;
    logic [WORD_W-1:0] u;
    logic [WORD_W-1:0] l;
    state_nxt = state_r;
    e = load_acc_sel_i ? state_r.ext_second : state_r.ext_first;
    u = load_acc_sel_i ? state_r.upper_second : state_r.upper_first;
    l = load_acc_sel_i ? state_r.lower_second : state_r.lower_first;
    if (status_wr_i) begin
      state_nxt.status = status_wdata_i;
    end
    if (result_valid_i) begin
      if (result_acc_sel_i) begin
        state_nxt.ext_second = result_i[ACC_W-1:PAIR_W];
        state_nxt.upper_second = res_upper;
        state_nxt.lower_second = res_lower;
      end else begin
        state_nxt.ext_first = result_i[ACC_W-1:PAIR_W];
        state_nxt.upper_first = res_upper;
        state_nxt.lower_first = res_lower;
      end
    end
    if (load_valid_i) begin
      unique case (load_dst_i)
        ABL_DST_X_LOW: state_nxt.x_low = hi_one;
        ABL_DST_X_HIGH: state_nxt.x_high = hi_one;
        ABL_DST_Y_LOW: state_nxt.y_low = hi_one;
        ABL_DST_Y_HIGH: state_nxt.y_high = hi_one;
        ABL_DST_X_PAIR: begin
          state_nxt.x_high = hi_x;
          state_nxt.x_low = hi_y;
        end
        ABL_DST_Y_PAIR: begin
          state_nxt.y_high = hi_x;
          state_nxt.y_low = hi_y;
        end
        ABL_DST_ACC_LOWER: l = hi_one;
        ABL_DST_ACC_UPPER: u = hi_one;
        ABL_DST_ACC_EXT: e = one_bus[EXT_W-1:0];
        ABL_DST_ACC_COMBINED: begin
          u = hi_x;
          l = hi_y;
        end
        ABL_DST_ACC_FULL: begin
          if (sixteen) begin
            u = hi_one;
            l = WORD_RST;
            e = sign_one;
          end else begin
            u = one_bus;
            l = WORD_RST;
            e = sign_one;
          end
        end
        ABL_DST_NONE: ;
        default: ;
      endcase
      if (load_dst_i == ABL_DST_ACC_FULL && load_use_y_i && sixteen) begin
        u = hi_x;
        l = hi_y;
        e = sign_x;
      end
      // Only accumulator destinations write back, so a register load never hides a result.
      if (load_dst_i inside {ABL_DST_ACC_LOWER, ABL_DST_ACC_UPPER, ABL_DST_ACC_EXT, ABL_DST_ACC_COMBINED,
                             ABL_DST_ACC_FULL}) begin
        if (load_acc_sel_i) begin
          state_nxt.ext_second = e;
          state_nxt.upper_second = u;
          state_nxt.lower_second = l;
        end else begin
          state_nxt.ext_first = e;
          state_nxt.upper_first = u;
          state_nxt.lower_first = l;
        end
      end
    end
    // Set wins over a clearing status write in the same cycle.
    if (store_valid_i && (store_src_i == ABL_SRC_ACC_FULL || store_src_i == ABL_SRC_ACC_PART)) begin
      state_nxt.status[SR_GROWTH_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '{SR_RST, WORD_RST, WORD_RST, WORD_RST, WORD_RST, EXT_RST, WORD_RST, WORD_RST,
                   EXT_RST, WORD_RST, WORD_RST};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign status_register_o = state_r.status;
  assign sixteen_bit_mode_o = sixteen;
  assign block_growth_flag_o = state_r.status[SR_GROWTH_BIT];
  assign input_x_low_o = state_r.x_low;
  assign input_x_high_o = state_r.x_high;
  assign input_y_low_o = state_r.y_low;
  assign input_y_high_o = state_r.y_high;
  assign acc_first_o = {state_r.ext_first, state_r.upper_first, state_r.lower_first};
  assign acc_second_o = {state_r.ext_second, state_r.upper_second, state_r.lower_second};

  // Operands seen by the arithmetic unit ignore low bytes in sixteen-bit mode.
  assign operand_x_o = sixteen ? {state_r.x_high[WORD_W-1:PAD_W], {PAD_W{1'b0}}, state_r.x_low[WORD_W-1:PAD_W],
                                  {PAD_W{1'b0}}} : {state_r.x_high, state_r.x_low};
  assign operand_y_o = sixteen ? {state_r.y_high[WORD_W-1:PAD_W], {PAD_W{1'b0}}, state_r.y_low[WORD_W-1:PAD_W],
                                  {PAD_W{1'b0}}} : {state_r.y_high, state_r.y_low};
  assign operand_acc_first_o = sixteen ? {state_r.ext_first, state_r.upper_first[WORD_W-1:PAD_W], {PAD_W{1'b0}},
                                          state_r.lower_first[WORD_W-1:PAD_W], {PAD_W{1'b0}}} : acc_first_o;
  assign operand_acc_second_o = sixteen ? {state_r.ext_second, state_r.upper_second[WORD_W-1:PAD_W], {PAD_W{1'b0}},
                                           state_r.lower_second[WORD_W-1:PAD_W], {PAD_W{1'b0}}} : acc_second_o;

endmodule : abl_alu_regs
`default_nettype wire

/* dv/abl_bus_model.sv */
// Model of the core data buses that feed the register file.
`timescale 1ns/100ps
`default_nettype none
module abl_bus_model (
  input wire logic sys_clk_i,
  input wire logic drive_i,
  input wire logic [23:0] x_i,
  input wire logic [23:0] y_i,
  output logic [23:0] x_data_bus_o,
  output logic [23:0] y_data_bus_o
);
  logic [47:0] last_r = '0;
  always_ff @(posedge sys_clk_i) if (drive_i) last_r <= {x_i, y_i};
  // A released bus shows the inverse of its last word, never a stale copy.
  assign x_data_bus_o = drive_i ? x_i : ~last_r[47:24];
  assign y_data_bus_o = drive_i ? y_i : ~last_r[23:0];
endmodule : abl_bus_model
`default_nettype wire

/* dv/abl_alu_regs_props.sv */
// Assertion checker for the register file ports.
`timescale 1ns/100ps
`default_nettype none
module abl_alu_regs_props
  import abl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_valid_i,
  input wire abl_dst_t load_dst_i,
  input wire logic load_use_y_i,
  input wire logic load_acc_sel_i,
  input wire logic [WORD_W-1:0] x_data_bus_i,
  input wire logic [WORD_W-1:0] y_data_bus_i,
  input wire logic store_valid_i,
  input wire abl_src_t store_src_i,
  input wire logic status_wr_i,
  input wire logic result_valid_i,
  input wire logic [SR_W-1:0] status_register_o,
  input wire logic sixteen_bit_mode_o,
  input wire logic block_growth_flag_o,
  input wire logic [WORD_W-1:0] input_x_high_o,
  input wire logic [ACC_W-1:0] acc_first_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic m;
  assign m = load_valid_i && sixteen_bit_mode_o && !load_acc_sel_i && !result_valid_i && !load_use_y_i;
  a_growth_set: assert property (store_valid_i && store_src_i inside {ABL_SRC_ACC_FULL, ABL_SRC_ACC_PART}
    |=> block_growth_flag_o) else $error("growth flag not set");
  a_growth_sticky: assert property (block_growth_flag_o && !status_wr_i |=> block_growth_flag_o)
    else $error("growth flag lost");
  a_growth_bit: assert property (block_growth_flag_o == status_register_o[SR_GROWTH_BIT])
    else $error("growth flag not at bit 7");
  a_mode_bit: assert property (sixteen_bit_mode_o == status_register_o[SR_SIXTEEN_BIT])
    else $error("mode bit mismatch");
  a_full_one: assert property (m && load_dst_i == ABL_DST_ACC_FULL |=>
    acc_first_o[47:32] == $past(x_data_bus_i[15:0]) && acc_first_o[23:8] == 16'h0000
    && acc_first_o[55:48] == {8{acc_first_o[47]}}) else $error("full load wrong");
  a_ext_load: assert property (m && load_dst_i == ABL_DST_ACC_EXT |=>
    acc_first_o[55:48] == $past(x_data_bus_i[7:0]) && acc_first_o[47:0] == $past(acc_first_o[47:0]))
    else $error("ext load wrong");
  a_upper_load: assert property (m && load_dst_i == ABL_DST_ACC_UPPER |=>
    acc_first_o[47:32] == $past(x_data_bus_i[15:0]) && $stable(acc_first_o[23:0])) else $error("upper load wrong");
  a_xhigh_load: assert property (m && load_dst_i == ABL_DST_X_HIGH |=>
    input_x_high_o[23:8] == $past(x_data_bus_i[15:0])) else $error("input load wrong");
endmodule : abl_alu_regs_props
bind abl_alu_regs abl_alu_regs_props u_props (.*);
`default_nettype wire

/* dv/testbench.sv */
// Self-checking testbench for the register file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import abl_pkg::*;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, load_valid_i = 1'b0, load_use_y_i = 1'b0, load_acc_sel_i = 1'b0, drv = 1'b0;
  logic store_valid_i = 1'b0, status_wr_i = 1'b0, result_valid_i = 1'b0, result_acc_sel_i = 1'b0;
  abl_dst_t load_dst_i = ABL_DST_NONE;
  abl_src_t store_src_i = ABL_SRC_NONE;
  logic [23:0] bx = '0, by = '0, status_wdata_i = '0, status_register_o, input_x_low_o, input_x_high_o;
  logic [23:0] input_y_low_o, input_y_high_o;
  wire logic [23:0] x_data_bus_i, y_data_bus_i;
  logic sixteen_bit_mode_o, block_growth_flag_o;
  logic [55:0] result_i = '0, p, acc_first_o, acc_second_o, operand_acc_first_o, operand_acc_second_o;
  logic [55:0] mk = 56'hff_ffff00_ffff00;
  logic [47:0] operand_x_o, operand_y_o;
  int n_fail = 0, checked = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  abl_alu_regs DUT (.*);
  abl_bus_model u_bus (.sys_clk_i(sys_clk_i), .drive_i(drv), .x_i(bx), .y_i(by), .x_data_bus_o(x_data_bus_i),
    .y_data_bus_o(y_data_bus_i));
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ld(input abl_dst_t d, input logic u, input logic s, input logic [23:0] x, input logic [23:0] y);
    @(posedge sys_clk_i);
    {load_valid_i, load_use_y_i, load_acc_sel_i, drv, bx, by} <= {4'hf & {1'b1, u, s, 1'b1}, x, y};
    load_dst_i <= d;
    @(posedge sys_clk_i);
    {load_valid_i, drv} <= 2'b00;
    #1;
  endtask : ld
  task automatic ctl(input logic w, input logic [23:0] wd, input logic st, input abl_src_t src);
    @(posedge sys_clk_i);
    {status_wr_i, status_wdata_i, store_valid_i} <= {w, wd, st};
    store_src_i <= src;
    @(posedge sys_clk_i);
    {status_wr_i, store_valid_i} <= 2'b00;
    #1;
  endtask : ctl
  task automatic t_loads();
    ctl(1'b1, 24'h020000, 1'b0, ABL_SRC_NONE);
    chk(sixteen_bit_mode_o, 1'b1);
    ld(ABL_DST_ACC_FULL, 1'b0, 1'b0, 24'h008001, 24'h0);
    chk(acc_first_o & mk, 56'hff_800100_000000);
    ld(ABL_DST_ACC_FULL, 1'b1, 1'b1, 24'h007fff, 24'h00abcd);
    chk(acc_second_o & mk, 56'h00_7fff00_abcd00);
    p = acc_first_o;
    ld(ABL_DST_ACC_UPPER, 1'b1, 1'b0, 24'h0, 24'hff1234);
    chk({acc_first_o[55:32], acc_first_o[23:0]}, {p[55:48], 16'h1234, p[23:0]});
    p = acc_first_o;
    ld(ABL_DST_ACC_EXT, 1'b0, 1'b0, 24'h12345a, 24'h0);
    chk(acc_first_o, {8'h5a, p[47:0]});
    ld(ABL_DST_ACC_COMBINED, 1'b0, 1'b0, 24'hff1111, 24'hee2222);
    chk(acc_first_o & mk, 56'h5a_111100_222200);
    chk(operand_acc_first_o, 56'h5a_111100_222200);
    ld(ABL_DST_Y_PAIR, 1'b0, 1'b0, 24'h003333, 24'h004444);
    chk({input_y_high_o, input_y_low_o}, 48'h333300_444400);
    chk(operand_y_o, 48'h333300_444400);
    ld(ABL_DST_X_PAIR, 1'b0, 1'b0, 24'hff1111, 24'hee2222);
    chk({input_x_high_o[23:8], input_x_low_o[23:8]}, 32'h11112222);
    chk(operand_x_o & 48'h0000ff_0000ff, 48'h0);
    ld(ABL_DST_X_HIGH, 1'b0, 1'b0, 24'h00cafe, 24'h0);
    ld(ABL_DST_Y_LOW, 1'b1, 1'b0, 24'h0, 24'h00beef);
    chk({input_x_high_o[23:8], input_y_low_o[23:8]}, 32'hcafebeef);
    @(posedge sys_clk_i);
    {result_valid_i, result_acc_sel_i, result_i} <= {2'b11, 56'h12_3456ff_9abcff};
    @(posedge sys_clk_i);
    result_valid_i <= 1'b0;
    #1;
    chk(operand_acc_second_o, 56'h12_345600_9abc00);
    ctl(1'b1, 24'h000000, 1'b0, ABL_SRC_NONE);
    ld(ABL_DST_ACC_FULL, 1'b0, 1'b0, 24'h123456, 24'h0);
    chk(acc_first_o, 56'h00_123456_000000);
    ctl(1'b1, 24'h020000, 1'b0, ABL_SRC_NONE);
    $display("test loads done");
  endtask : t_loads
  task automatic t_flag();
    ctl(1'b0, 24'h0, 1'b1, ABL_SRC_ACC_FULL);
    chk(status_register_o[7], 1'b1);
    ctl(1'b0, 24'h0, 1'b1, ABL_SRC_REG);
    chk(block_growth_flag_o, 1'b1);
    ctl(1'b1, 24'h020000, 1'b0, ABL_SRC_NONE);
    chk(block_growth_flag_o, 1'b0);
    ctl(1'b1, 24'h020000, 1'b1, ABL_SRC_ACC_PART);
    chk(block_growth_flag_o, 1'b1);
    $display("test flag done");
  endtask : t_flag
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_loads();
    t_flag();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
